//--- pkg/counter_relay_pkg.sv
// Purpose: shared constants for the sixteen-channel up/down event counter relay bank.
// Assumes: one 125 MHz clock, a scan strobe from the program engine on the same clock.
// Notes:   counter numbers 1..16 map to indices 0..15 throughout.
// Behaviour
// - sixteen independent counters, each with count, setpoint, contact and coils.
// - contact active while count is at or above the setpoint.
// - count changes by one per rising count-coil edge, never on a level.
// - direction coil off counts up, direction coil on counts down.
// - while the clear coil is active the count is forced to zero.
// - setpoint is a constant from zero to thirty-two thousand.
// - count holds at thirty-two thousand until direction turns to down.
// - count holds at zero until direction turns to up.
// - counters 1-12 plain; 13-14 may be high speed; 15-16 may be frequency.
// - mode selects plain, high-speed, or frequency measurement behaviour.
// - high-speed counters take their count input straight from fast inputs one and two.
// - a retentive counter keeps its count over run-to-stop and power loss.
// - retention only for counters 5-8 and 13-16.
// - starting in run, a retentive counter resumes from its saved count.
// - without edges or clear the count holds indefinitely.
// - counting down, contact drops once count is one below setpoint.
// - a per-counter flag shows or hides its parameters in the runtime menu.
package counter_relay_pkg;
  // bank shape
  localparam int NUM_COUNTERS = 16;
  localparam int COUNT_W      = 15;
  localparam int MODE_W       = 2;
  localparam int NUM_FAST     = 4;
  localparam int FIRST_FAST   = 12;  // index of the first counter wired to a fast input
  localparam int FIRST_FREQ   = 14;  // index of the first frequency-capable counter
  // count range
  localparam logic [COUNT_W-1:0] COUNT_MAX  = 15'h7D00;  // 32000
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 15'h0000;
  // operating modes
  localparam logic [MODE_W-1:0] MODE_NORMAL     = 2'h0;
  localparam logic [MODE_W-1:0] MODE_HIGH_SPEED = 2'h1;
  localparam logic [MODE_W-1:0] MODE_FREQUENCY  = 2'h2;
  // which counters may take which options
  localparam logic [NUM_COUNTERS-1:0] RETAIN_ALLOWED = 16'hF0F0;
  localparam logic [NUM_COUNTERS-1:0] HIGH_ALLOWED   = 16'h3000;
  localparam logic [NUM_COUNTERS-1:0] FREQ_ALLOWED   = 16'hC000;
  // frequency gate time
  localparam int CLK_FREQ_HZ  = 125_000_000;
  localparam int GATE_TIME_MS = 1000;
  localparam int GATE_CYCLES  = (CLK_FREQ_HZ / 1000) * GATE_TIME_MS;
endpackage

//--- src/fast_input_sync.sv
// Purpose: bring the fast digital inputs into the clock domain and flag rising edges.
// Assumes: inputs are asynchronous pins, slow against the 8 ns clock.
// Notes:   edge detection looks only at the second stage of the synchroniser.
`timescale 1ns/10ps
`default_nettype none
module fast_input_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // pins in
  input  wire logic [WIDTH-1:0] pin,
  // synchronised view
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] last;

  // two-stage synchroniser, then a delay stage for the edge
  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta  <= '0;
      level <= '0;
      last  <= '0;
    end else begin
      meta  <= pin;
      level <= meta;
      last  <= level;
    end
  end

  // one-cycle pulse per rising edge
  assign rise = level & ~last;
endmodule
`default_nettype wire

//--- src/count_cell.sv
// Purpose: one saturating up/down count register with clear and load.
// Assumes: step, clear and load are single-cycle pulses or levels from the bank.
// Notes:   priority is clear, then load, then step.
`timescale 1ns/10ps
`default_nettype none
module count_cell
  import counter_relay_pkg::*;
(
  // clock and reset
  input  wire logic                                  clk,
  input  wire logic                                  nrst,
  // controls
  input  wire logic                                  step,
  input  wire logic                                  down,
  input  wire logic                                  clear,
  input  wire logic                                  load,
  input  wire logic [counter_relay_pkg::COUNT_W-1:0] load_value,
  // state
  output logic      [counter_relay_pkg::COUNT_W-1:0] count
);
  logic [COUNT_W-1:0] next_count;
  logic               at_top;
  logic               at_bottom;

  assign at_top    = (count >= COUNT_MAX);
  assign at_bottom = (count == COUNT_ZERO);

  // saturation: edges past either end are dropped, so the count waits for a direction change
  always_comb begin
    next_count = count;
    if (clear) begin
      next_count = COUNT_ZERO;
    end else if (load) begin
      next_count = (load_value > COUNT_MAX) ? COUNT_MAX : load_value;
    end else if (step) begin
      if (down) begin
        if (!at_bottom) begin
          next_count = count - 15'h0001;
        end
      end else begin
        if (!at_top) begin
          next_count = count + 15'h0001;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      count <= COUNT_ZERO;
    end else begin
      count <= next_count;
    end
  end
endmodule
`default_nettype wire

//--- src/updown_event_counter_relay.sv
// Purpose: bank of sixteen up/down event counters driven by the program's coils.
// Assumes: SCAN_TICK pulses once per program scan; coils and RUN are on the CLK domain.
// Notes:   contacts lag the count by one clock; the nonvolatile store itself lives outside.
`timescale 1ns/10ps
`default_nettype none
module updown_event_counter_relay
  import counter_relay_pkg::*;
#(
  parameter int GATE_CYCLES_P = counter_relay_pkg::GATE_CYCLES
) (
  // clock and reset
  input  wire logic                                                         CLK,
  input  wire logic                                                         NRST,
  // program scan and run state
  input  wire logic                                                         SCAN_TICK,
  input  wire logic                                                         RUN,
  // coils from the program
  input  wire logic [counter_relay_pkg::NUM_COUNTERS-1:0]                   COUNT_COIL,
  input  wire logic [counter_relay_pkg::NUM_COUNTERS-1:0]                   DIRECTION_COIL,
  input  wire logic [counter_relay_pkg::NUM_COUNTERS-1:0]                   CLEAR_COIL,
  // fast digital input pins one to four
  input  wire logic [counter_relay_pkg::NUM_FAST-1:0]                       FAST_IN,
  // per-counter configuration
  input  wire logic [counter_relay_pkg::NUM_COUNTERS-1:0][counter_relay_pkg::MODE_W-1:0]  MODE,
  input  wire logic [counter_relay_pkg::NUM_COUNTERS-1:0][counter_relay_pkg::COUNT_W-1:0] SETPOINT,
  input  wire logic [counter_relay_pkg::NUM_COUNTERS-1:0]                   RETAIN_SEL,
  input  wire logic [counter_relay_pkg::NUM_COUNTERS-1:0]                   SHOW_PARAM,
  // saved counts offered back at start of run
  input  wire logic                                                         RESTORE_VALID,
  input  wire logic [counter_relay_pkg::NUM_COUNTERS-1:0][counter_relay_pkg::COUNT_W-1:0] SAVED_COUNT,
  // results
  output logic      [counter_relay_pkg::NUM_COUNTERS-1:0]                   COUNTER_RELAY_CONTACT,
  output logic      [counter_relay_pkg::NUM_COUNTERS-1:0][counter_relay_pkg::COUNT_W-1:0] COUNT_VALUE,
  output logic      [counter_relay_pkg::NUM_COUNTERS-1:0]                   RETAIN_ACTIVE,
  output logic      [counter_relay_pkg::NUM_COUNTERS-1:0]                   PARAM_VISIBLE
);
  import counter_relay_pkg::*;

  localparam int GATE_W = $clog2(GATE_CYCLES_P + 1);
  localparam logic [GATE_W-1:0] GATE_LAST = GATE_W'(GATE_CYCLES_P - 1);
  localparam int NUM_FREQ = NUM_COUNTERS - FIRST_FREQ;

  typedef enum logic [0:0] {GATE_IDLE, GATE_OPEN} gate_state_e;

  // ****************************************************************
  // run state and scan-sampled coils
  // ****************************************************************
  logic                    run_q;
  logic                    run_start;
  logic                    count_ok;
  logic [NUM_COUNTERS-1:0] coil_last;
  logic [NUM_COUNTERS-1:0] dir_held;
  logic [NUM_COUNTERS-1:0] clear_held;
  logic [NUM_COUNTERS-1:0] enable_held;
  logic [NUM_COUNTERS-1:0] scan_edge;

  // run start is the first cycle of RUN; counting only while running
  assign run_start = RUN & ~run_q;
  assign count_ok  = RUN & run_q;

  assign scan_edge = {NUM_COUNTERS{SCAN_TICK}} & COUNT_COIL & ~coil_last;

  // coil memory updates only on the scan strobe, so a level between scans is one sample
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      run_q       <= 1'b0;
      coil_last   <= '0;
      dir_held    <= '0;
      clear_held  <= '0;
      enable_held <= '0;
    end else begin
      run_q <= RUN;
      if (SCAN_TICK) begin
        coil_last   <= COUNT_COIL;
        dir_held    <= DIRECTION_COIL;
        clear_held  <= CLEAR_COIL;
        enable_held <= COUNT_COIL;
      end
    end
  end

  // ****************************************************************
  // fast input pins
  // ****************************************************************
  logic [NUM_FAST-1:0] fast_level;
  logic [NUM_FAST-1:0] fast_rise;

  // pins bypass the scan, only synchronised
  fast_input_sync #(
    .WIDTH (NUM_FAST)
  ) u_fast_sync (
    .clk   (CLK),
    .nrst  (NRST),
    .pin   (FAST_IN),
    .level (fast_level),
    .rise  (fast_rise)
  );

  // ****************************************************************
  // frequency measurement for the last two counters
  // ****************************************************************
  logic [NUM_FREQ-1:0]               freq_load;
  logic [NUM_FREQ-1:0]               freq_clear;
  logic [NUM_FREQ-1:0][COUNT_W-1:0]  freq_result;
  logic [NUM_COUNTERS-1:0]           is_freq;

  genvar f;
  generate
    for (f = 0; f < NUM_FREQ; f++) begin : g_freq
      gate_state_e        state;
      gate_state_e        next_state;
      logic [GATE_W-1:0]  gate_cnt;
      logic [COUNT_W-1:0] pulses;
      logic               enable;
      logic               gate_end;
      logic               fast_edge;
      logic               pulses_full;

      // count coil acts as the measurement enable; dropped enable stops it, clear coil only zeroes the result
      assign enable      = is_freq[FIRST_FREQ + f] & enable_held[FIRST_FREQ + f] & count_ok;
      assign gate_end    = (state == GATE_OPEN) & (gate_cnt == GATE_LAST);
      assign fast_edge   = fast_rise[FIRST_FREQ - FIRST_FAST + f];
      assign pulses_full = (pulses >= COUNT_MAX);

      // enable and clear gate the result path
      assign freq_load[f]   = gate_end & ~clear_held[FIRST_FREQ + f];
      assign freq_clear[f]  = is_freq[FIRST_FREQ + f] & (~enable | clear_held[FIRST_FREQ + f]);
      assign freq_result[f] = (fast_edge & ~pulses_full) ? pulses + 15'h0001 : pulses;

      always_comb begin
        next_state = state;
        case (state)
          GATE_IDLE: begin
            if (enable) begin
              next_state = GATE_OPEN;
            end
          end
          GATE_OPEN: begin
            if (!enable) begin
              next_state = GATE_IDLE;
            end
          end
          default: begin
            next_state = GATE_IDLE;
          end
        endcase
      end

      // pulses over one gate give the frequency
      always_ff @(posedge CLK) begin
        if (!NRST) begin
          state    <= GATE_IDLE;
          gate_cnt <= '0;
          pulses   <= COUNT_ZERO;
        end else begin
          state <= next_state;
          if ((state != GATE_OPEN) || gate_end || !enable) begin
            gate_cnt <= '0;
            pulses   <= COUNT_ZERO;
          end else begin
            gate_cnt <= gate_cnt + 1'b1;
            if (fast_edge && !pulses_full) begin
              pulses <= pulses + 15'h0001;
            end
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // per-counter control and count cells
  // ****************************************************************
  logic [NUM_COUNTERS-1:0] is_high;
  logic [NUM_COUNTERS-1:0] retain_eff;
  logic [NUM_COUNTERS-1:0] next_contact;

  genvar i;
  generate
    for (i = 0; i < NUM_COUNTERS; i++) begin : g_cnt
      logic               step;
      logic               down;
      logic               clear;
      logic               load;
      logic [COUNT_W-1:0] load_value;
      logic [COUNT_W-1:0] count;
      logic [COUNT_W-1:0] sp_eff;
      logic               fast_edge;
      logic               start_clear;
      logic               start_load;
      logic               normal_step;
      logic               normal_clear;
      logic               high_step;

      // options outside the allowed counters fall back to plain counting
      assign is_high[i] = HIGH_ALLOWED[i] & (MODE[i] == MODE_HIGH_SPEED);
      assign is_freq[i] = FREQ_ALLOWED[i] & (MODE[i] == MODE_FREQUENCY);

      // retention masked to the allowed counters
      assign retain_eff[i] = RETAIN_ALLOWED[i] & RETAIN_SEL[i];

      assign start_clear = run_start & ~retain_eff[i];
      // retentive counters resume from the saved value
      assign start_load  = run_start & retain_eff[i] & RESTORE_VALID;

      // fast pins only exist for the upper four counters
      if (i >= FIRST_FAST) begin : g_pin
        assign fast_edge = fast_rise[i - FIRST_FAST];
      end else begin : g_nopin
        assign fast_edge = 1'b0;
      end

      // plain counters act on the scan; clear wins
      assign normal_clear = SCAN_TICK & CLEAR_COIL[i];
      assign normal_step  = scan_edge[i] & count_ok;
      // high-speed steps straight from the pin
      assign high_step    = fast_edge & count_ok & ~clear_held[i];

      assign step  = is_high[i] ? high_step : (is_freq[i] ? 1'b0 : normal_step);
      assign down  = is_high[i] ? dir_held[i] : DIRECTION_COIL[i];
      assign clear = start_clear | (is_freq[i] ? 1'b0 : (is_high[i] ? clear_held[i] : normal_clear));
      if (i >= FIRST_FREQ) begin : g_fload
        assign load       = start_load | (is_freq[i] & (freq_load[i - FIRST_FREQ] | freq_clear[i - FIRST_FREQ]));
        assign load_value = start_load ? SAVED_COUNT[i] :
                            (freq_clear[i - FIRST_FREQ] ? COUNT_ZERO : freq_result[i - FIRST_FREQ]);
      end else begin : g_nfload
        assign load       = start_load;
        assign load_value = SAVED_COUNT[i];
      end

      count_cell u_cell (
        .clk        (CLK),
        .nrst       (NRST),
        .step       (step),
        .down       (down),
        .clear      (clear),
        .load       (load),
        .load_value (load_value),
        .count      (count)
      );

      // setpoint limited to the counting range
      assign sp_eff = (SETPOINT[i] > COUNT_MAX) ? COUNT_MAX : SETPOINT[i];

      assign next_contact[i] = (count >= sp_eff);

      assign COUNT_VALUE[i] = count;
    end
  endgenerate

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  // contacts and flags come from flops so the program sees clean levels
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      COUNTER_RELAY_CONTACT <= '0;
      RETAIN_ACTIVE         <= '0;
      PARAM_VISIBLE         <= '0;
    end else begin
      COUNTER_RELAY_CONTACT <= next_contact;
      RETAIN_ACTIVE         <= retain_eff;
      PARAM_VISIBLE         <= SHOW_PARAM;
    end
  end
endmodule
`default_nettype wire

//--- verif/counter_relay_monitor.sv
// Purpose: port-level checks on the counter relay bank.
// Assumes: one clock; NRST synchronous, active low.
// Notes:   a count edge is the coil level at a scan against the level at the last scan.
`timescale 1ns/10ps
`default_nettype none
module counter_relay_monitor
  import counter_relay_pkg::*;
#(
  parameter int GATE_CYCLES_P = 100
) (
  // clock, reset and scan
  input wire logic                                 CLK,
  input wire logic                                 NRST,
  input wire logic                                 SCAN_TICK,
  input wire logic                                 RUN,
  // coils and configuration
  input wire logic [NUM_COUNTERS-1:0]              COUNT_COIL,
  input wire logic [NUM_COUNTERS-1:0]              DIRECTION_COIL,
  input wire logic [NUM_COUNTERS-1:0]              CLEAR_COIL,
  input wire logic [NUM_COUNTERS-1:0][MODE_W-1:0]  MODE,
  input wire logic [NUM_COUNTERS-1:0][COUNT_W-1:0] SETPOINT,
  input wire logic [NUM_COUNTERS-1:0]              RETAIN_SEL,
  // results
  input wire logic [NUM_COUNTERS-1:0]              COUNTER_RELAY_CONTACT,
  input wire logic [NUM_COUNTERS-1:0][COUNT_W-1:0] COUNT_VALUE,
  input wire logic [NUM_COUNTERS-1:0]              RETAIN_ACTIVE
);
  // ************
  // scan helpers
  // ************
  logic                    run_q;
  logic [NUM_COUNTERS-1:0] coil_q;
  // coil level at the last scan, so a held coil never looks like a new edge
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      run_q  <= 1'b0;
      coil_q <= '0;
    end else begin
      run_q <= RUN;
      if (SCAN_TICK) begin
        coil_q <= COUNT_COIL;
      end
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  property p_retain; $past(NRST) |-> RETAIN_ACTIVE == ($past(RETAIN_SEL) & RETAIN_ALLOWED); endproperty
  a_retain: assert property (p_retain) else $error("retention on a counter that cannot keep it");
  c_start: cover property ($rose(RUN));
  c_top: cover property (COUNT_VALUE[4] == COUNT_MAX);
  c_clear: cover property (SCAN_TICK && RUN && CLEAR_COIL[0]);
  c_fast: cover property (MODE[12] == MODE_HIGH_SPEED && $changed(COUNT_VALUE[12]));
  c_freq: cover property (MODE[14] == MODE_FREQUENCY && COUNT_VALUE[14] == 15'h000A);
  // ************
  // per counter
  // ************
  for (genvar i = 0; i < NUM_COUNTERS; i++) begin : g_ch
    // scan in run for a plain counter, and a counted edge without clear
    wire               tk = SCAN_TICK && RUN && run_q && MODE[i] == MODE_NORMAL;
    wire               st = tk && !CLEAR_COIL[i] && COUNT_COIL[i] && !coil_q[i];
    wire [COUNT_W-1:0] sp = (SETPOINT[i] > COUNT_MAX) ? COUNT_MAX : SETPOINT[i];
    property p_contact; $past(NRST) |-> COUNTER_RELAY_CONTACT[i] == ($past(COUNT_VALUE[i]) >= $past(sp)); endproperty
    a_contact: assert property (p_contact) else $error("contact disagrees with count");
    property p_hold; !SCAN_TICK && RUN && run_q && MODE[i] == MODE_NORMAL |=> $stable(COUNT_VALUE[i]); endproperty
    a_hold: assert property (p_hold) else $error("count moved without a scan");
    property p_clear; tk && CLEAR_COIL[i] |=> COUNT_VALUE[i] == COUNT_ZERO; endproperty
    a_clear: assert property (p_clear) else $error("clear did not zero the count");
    property p_up; st && !DIRECTION_COIL[i] && COUNT_VALUE[i] != COUNT_MAX
      |=> COUNT_VALUE[i] == $past(COUNT_VALUE[i]) + 15'h0001; endproperty
    a_up: assert property (p_up) else $error("up edge did not add one");
    property p_top; st && !DIRECTION_COIL[i] && COUNT_VALUE[i] == COUNT_MAX |=> COUNT_VALUE[i] == COUNT_MAX; endproperty
    a_top: assert property (p_top) else $error("count left the top on an up edge");
    property p_zero; st && DIRECTION_COIL[i] && COUNT_VALUE[i] == COUNT_ZERO |=> COUNT_VALUE[i] == COUNT_ZERO; endproperty
    a_zero: assert property (p_zero) else $error("count left zero on a down edge");
    property p_start; $rose(RUN) && !(RETAIN_SEL[i] && RETAIN_ALLOWED[i]) |=> COUNT_VALUE[i] == COUNT_ZERO; endproperty
    a_start: assert property (p_start) else $error("plain counter kept its count at run start");
  end
endmodule
bind updown_event_counter_relay counter_relay_monitor #(.GATE_CYCLES_P(GATE_CYCLES_P)) i_counter_relay_monitor (
  .CLK(CLK), .NRST(NRST), .SCAN_TICK(SCAN_TICK), .RUN(RUN), .COUNT_COIL(COUNT_COIL),
  .DIRECTION_COIL(DIRECTION_COIL), .CLEAR_COIL(CLEAR_COIL), .MODE(MODE), .SETPOINT(SETPOINT),
  .RETAIN_SEL(RETAIN_SEL), .COUNTER_RELAY_CONTACT(COUNTER_RELAY_CONTACT), .COUNT_VALUE(COUNT_VALUE),
  .RETAIN_ACTIVE(RETAIN_ACTIVE)
);
`default_nettype wire

//--- verif/coil_program_model.sv
// Purpose: stands in for the user program that drives the counter coils.
// Assumes: the bench posts coil wishes; they reach the coils only at scan boundaries.
// Notes:   slow stretches the scan threefold so sparse ticks are seen as well.
`timescale 1ns/10ps
`default_nettype none
module coil_program_model
  import counter_relay_pkg::*;
(
  // clock and pace
  input  wire logic                    clk,
  input  wire logic                    slow,
  // wishes from the bench
  input  wire logic [NUM_COUNTERS-1:0] want_count,
  input  wire logic [NUM_COUNTERS-1:0] want_dir,
  input  wire logic [NUM_COUNTERS-1:0] want_clear,
  // scan strobe and coils
  output logic                         scan_tick,
  output logic      [NUM_COUNTERS-1:0] count_coil,
  output logic      [NUM_COUNTERS-1:0] direction_coil,
  output logic      [NUM_COUNTERS-1:0] clear_coil
);
  int phase;
  initial begin
    phase = 0;
    scan_tick = 1'b0;
    count_coil = '0;
    direction_coil = '0;
    clear_coil = '0;
  end
  // one driver, one change per scan
  // coils move only after a tick, so each pulse spans a whole scan; fast pins are never read
  always @(negedge clk) begin
    phase <= (phase >= (slow ? 11 : 3)) ? 0 : phase + 1;
    scan_tick <= (phase >= (slow ? 11 : 3));
    if (scan_tick) begin
      count_coil <= want_count;
      direction_coil <= want_dir;
      clear_coil <= want_clear;
    end
  end
endmodule
`default_nettype wire

//--- verif/test_updown_event_counter_relay.sv
// Purpose: self-checking bench for the counter relay bank.
// Assumes: coils come from the program model; the bench owns run state and fast pins.
// Notes:   the top limit is reached through a restored count, not thirty-two thousand scans.
`timescale 1ns/10ps
`default_nettype none
module test_updown_event_counter_relay;
  import counter_relay_pkg::*;
  logic                                  CLK, NRST, SCAN_TICK, RUN, RESTORE_VALID, slow;
  logic [NUM_COUNTERS-1:0]               COUNT_COIL, DIRECTION_COIL, CLEAR_COIL, RETAIN_SEL, SHOW_PARAM;
  logic [NUM_COUNTERS-1:0]               COUNTER_RELAY_CONTACT, RETAIN_ACTIVE, PARAM_VISIBLE, wc, wd, wr;
  logic [NUM_FAST-1:0]                   FAST_IN;
  logic [NUM_COUNTERS-1:0][MODE_W-1:0]   MODE;
  logic [NUM_COUNTERS-1:0][COUNT_W-1:0]  SETPOINT, SAVED_COUNT, COUNT_VALUE;
  int                                    miscompares, checks_done, n;
  // count coil, direction, clear, expected count, expected contact (setpoint two)
  logic [5:0]                            rows [15] = '{6'b100010, 6'b000010, 6'b100101, 6'b100101, 6'b010101,
    6'b110010, 6'b010010, 6'b110000, 6'b010000, 6'b110000, 6'b000000, 6'b100010, 6'b001000, 6'b101000, 6'b000000};
  updown_event_counter_relay #(.GATE_CYCLES_P(100)) i_updown_event_counter_relay (.CLK(CLK), .NRST(NRST),
    .SCAN_TICK(SCAN_TICK), .RUN(RUN), .COUNT_COIL(COUNT_COIL), .DIRECTION_COIL(DIRECTION_COIL),
    .CLEAR_COIL(CLEAR_COIL), .FAST_IN(FAST_IN), .MODE(MODE), .SETPOINT(SETPOINT), .RETAIN_SEL(RETAIN_SEL),
    .SHOW_PARAM(SHOW_PARAM), .RESTORE_VALID(RESTORE_VALID), .SAVED_COUNT(SAVED_COUNT),
    .COUNTER_RELAY_CONTACT(COUNTER_RELAY_CONTACT), .COUNT_VALUE(COUNT_VALUE),
    .RETAIN_ACTIVE(RETAIN_ACTIVE), .PARAM_VISIBLE(PARAM_VISIBLE));
  coil_program_model i_coil_program_model (.clk(CLK), .slow(slow), .want_count(wc), .want_dir(wd),
    .want_clear(wr), .scan_tick(SCAN_TICK), .count_coil(COUNT_COIL), .direction_coil(DIRECTION_COIL),
    .clear_coil(CLEAR_COIL));
  // ************
  // helpers
  // ************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // bounded wait for a scan tick
  task automatic tick;
    int k;
    k = 0;
    @(posedge CLK);
    while (SCAN_TICK !== 1'b1 && k < 40) begin
      @(posedge CLK);
      k++;
    end
  endtask
  // post coils, let the second tick take them, return once count and contact settled
  task automatic scan(input logic [15:0] c, input logic [15:0] d, input logic [15:0] r);
    @(negedge CLK);
    wc <= c;
    wd <= d;
    wr <= r;
    tick();
    tick();
    @(posedge CLK);
    @(negedge CLK);
  endtask
  task automatic tally_and_finish;
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // clock and hang guard
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  initial begin
    #80000;
    miscompares++;
    tally_and_finish();
  end
  // ************
  // main sequence
  // ************
  initial begin
    {NRST, RUN, RESTORE_VALID, slow, wc, wd, wr, FAST_IN, MODE, SAVED_COUNT} = '0;
    SETPOINT = {16{15'h0002}};
    RETAIN_SEL = 16'hFFFF;
    SHOW_PARAM = 16'hA5C3;
    repeat (6) @(negedge CLK);
    chk(COUNT_VALUE[0], 0);
    chk(COUNTER_RELAY_CONTACT, 0);
    NRST <= 1'b1;
    repeat (2) @(negedge CLK);
    RUN <= 1'b1;
    chk(PARAM_VISIBLE, 16'hA5C3);
    chk(RETAIN_ACTIVE, RETAIN_ALLOWED);
    // the table runs on all sixteen counters at once
    foreach (rows[k]) begin
      scan({16{rows[k][5]}}, {16{rows[k][4]}}, {16{rows[k][3]}});
      for (n = 0; n < 16; n++) chk(COUNT_VALUE[n], rows[k][2:1]);
      chk(COUNTER_RELAY_CONTACT, {16{rows[k][0]}});
    end
    // run start with saved counts one below the top
    @(negedge CLK);
    RUN <= 1'b0;
    // even counters get an out-of-range setpoint that must act as the top of the range
    SETPOINT <= {8{15'h7FFF, COUNT_MAX}};
    SAVED_COUNT <= {16{COUNT_MAX - 15'h0001}};
    RESTORE_VALID <= 1'b1;
    repeat (2) @(negedge CLK);
    RUN <= 1'b1;
    repeat (3) @(negedge CLK);
    for (n = 0; n < 16; n++) chk(COUNT_VALUE[n], RETAIN_ALLOWED[n] ? COUNT_MAX - 15'h0001 : 0);
    slow <= 1'b1;
    scan(16'hFFFF, 0, 0);
    scan(0, 0, 0);
    scan(16'hFFFF, 0, 0);
    chk(COUNT_VALUE[4], COUNT_MAX);
    chk(COUNT_VALUE[0], 2);
    chk(COUNTER_RELAY_CONTACT, RETAIN_ALLOWED);
    // stopped: edges are ignored and counts freeze
    RUN <= 1'b0;
    scan(0, 0, 0);
    scan(16'hFFFF, 0, 0);
    chk(COUNT_VALUE[4], COUNT_MAX);
    RESTORE_VALID <= 1'b0;
    RUN <= 1'b1;
    repeat (3) @(negedge CLK);
    chk(COUNT_VALUE[4], COUNT_MAX);
    chk(COUNT_VALUE[0], 0);
    scan(0, 16'hFFFF, 0);
    scan(16'hFFFF, 16'hFFFF, 0);
    chk(COUNT_VALUE[4], COUNT_MAX - 15'h0001);
    chk(COUNTER_RELAY_CONTACT[4], 0);
    // fast pin counting on counter thirteen; counter fourteen stays plain
    slow <= 1'b0;
    MODE[12] <= MODE_HIGH_SPEED;
    repeat (3) begin
      @(negedge CLK);
      FAST_IN <= 4'h3;
      repeat (3) @(negedge CLK);
      FAST_IN <= 4'h0;
      repeat (3) @(negedge CLK);
    end
    repeat (6) @(negedge CLK);
    chk(COUNT_VALUE[12], COUNT_MAX - 15'h0004);
    chk(COUNT_VALUE[13], COUNT_MAX - 15'h0001);
    // frequency on counter fifteen: a ten-cycle square wave gives ten rises in any full gate
    MODE[14] <= MODE_FREQUENCY;
    repeat (25) begin
      FAST_IN <= 4'h4;
      repeat (5) @(negedge CLK);
      FAST_IN <= 4'h0;
      repeat (5) @(negedge CLK);
    end
    chk(COUNT_VALUE[14], 10);
    scan(16'hFFFF, 16'hFFFF, 16'h4000);
    chk(COUNT_VALUE[14], 0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
